// >>> design/acr_cfg_regs.v
// configuration register bank of the converter output path and offset loop
//
// How it works
// RQ1: clock and data drive double bits select 100 or 50 ohm load.
// RQ2: format field 00 follows pin, 10 twos complement, 11 offset binary.
// RQ3: offset loop runs when enable bit 5 of format register set.
// RQ4: fixed output word built from high D13..D6 and low D5..D0 bits.
// RQ5: standard 00/10 follows pin, 01 forces DDR, 11 forces parallel.
// RQ6: rising edge shift applies only while its enable bit 3 set.
// RQ7: differential rise codes: 01 500ps, 11 200ps, 10 align, 00 default.
// RQ8: single-ended rise codes: 01 100ps, 10 200ps, 11 1.5ns.
// RQ9: falling edge shift applies only while interface bit 0 set.
// RQ10: differential fall codes: 01 400ps, 11 200ps, 10 align, 00 default.
// RQ11: single-ended fall advance: 01 100ps, 10 200ps, 11 1.5ns.
// RQ12: short path off bit 3 clear bypasses gain, patterns and offset correction; the code gates only the offset loop and hold.
// RQ13: quick sleep powers converter and output buffers down, reference stays.
// RQ14: full sleep powers converter, references and output buffers down.
// RQ15: output pins off powers pins down into high impedance.
// RQ16: swing code honoured only when override enable equals 11.
// RQ17: controller sets high freq boost above 230 MHz inputs.
// RQ18: corrected output converges to mid-code plus signed 6-bit shift.
// RQ19: hold bit freezes the offset estimate, last estimate still applied.
// RQ20: loop period code 0000 gives 1M cycles, doubling up to 2G.
// RQ21: slow rate mode enabled only by code 11 on fast variants.
// RQ22: controller writes zero into every unused bit.
// RQ23: software reset bit or reset pin restores defaults; bit self-clears.
// RQ24: one write updates every field of the register together.
// RQ25: value holds until the next write to that address or reset.
`timescale 1ns/100ps
`include "acr_map.vh"

module acr_cfg_regs #(
   parameter WIDE_VARIANT = 1'b1, // 1 = 14-bit part, 0 = 12-bit part
   parameter FAST_VARIANT = 1'b1  // 1 = part where slow rate field is usable
) (
   sys_clk,
   rst,
   wr_stb,
   wr_addr,
   wr_data,
   sw_reset,
   swing_code,
   format_select_pin,
   clock_drive_double,
   data_drive_double,
   twos_complement_out,
   offset_loop_enable,
   fixed_output_word,
   ddr_output,
   cmos_clk_strength,
   rise_shift_ps,
   rise_align,
   fall_shift_ps,
   fall_align,
   short_path_off,
   core_powered,
   ref_powered,
   out_buf_powered,
   pins_hiz,
   swing_override,
   swing_value,
   high_freq_boost,
   offset_target,
   offset_estimate_hold,
   offset_loop_log2,
   slow_rate_mode
);
   input              sys_clk;
   input              rst;
   input              wr_stb;
   input  [7:0]       wr_addr;
   input  [7:0]       wr_data;
   input              sw_reset;
   input  [5:0]       swing_code;
   input              format_select_pin;
   output reg         clock_drive_double;
   output reg         data_drive_double;
   output reg         twos_complement_out;
   output reg         offset_loop_enable;
   output reg [13:0]  fixed_output_word;
   output reg         ddr_output;
   output reg [1:0]   cmos_clk_strength;
   output reg [10:0]  rise_shift_ps;
   output reg         rise_align;
   output reg [10:0]  fall_shift_ps;
   output reg         fall_align;
   output reg         short_path_off;
   output reg         core_powered;
   output reg         ref_powered;
   output reg         out_buf_powered;
   output reg         pins_hiz;
   output reg         swing_override;
   output reg [5:0]   swing_value;
   output reg         high_freq_boost;
   output reg [5:0]   offset_target;
   output reg         offset_estimate_hold;
   output reg [4:0]   offset_loop_log2;
   output reg         slow_rate_mode;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: the format pin and the serial strobe come from outside
   reg [1:0] pin_sync_ff;
   reg [1:0] stb_sync_ff;
   reg [1:0] srst_sync_ff;
   reg       stb_seen_ff;
   // address and data pass two stages as well; they are only used once the
   // synchronised strobe shows they were taken at an edge where the strobe was high
   reg [7:0] addr_sync_ff;
   reg [7:0] data_sync_ff;
   reg [7:0] addr_ff;
   reg [7:0] data_ff;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_sync_ff  <= 2'h0;
         stb_sync_ff  <= 2'h0;
         srst_sync_ff <= 2'h0;
         stb_seen_ff  <= 1'b0;
         addr_sync_ff <= 8'h00;
         data_sync_ff <= 8'h00;
         addr_ff      <= 8'h00;
         data_ff      <= 8'h00;
      end else begin
         pin_sync_ff  <= {pin_sync_ff[0], format_select_pin};
         stb_sync_ff  <= {stb_sync_ff[0], wr_stb};
         srst_sync_ff <= {srst_sync_ff[0], sw_reset};
         stb_seen_ff  <= stb_sync_ff[1];
         // address and data are steady for a whole strobe, so plain stages
         // line them up with the strobe synchroniser
         addr_sync_ff <= wr_addr;
         data_sync_ff <= wr_data;
         addr_ff      <= addr_sync_ff;
         data_ff      <= data_sync_ff;
      end
   end

   // one write per rising strobe, taken after synchronisation; the strobe has
   // to be high at one edge only, where address and data enter the first stage
   // with it, and a strobe that falls between two edges may be missed entirely
   wire wr_go = stb_sync_ff[1] & ~stb_seen_ff;
   wire clr   = srst_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // register storage, all bits of one address written together
   reg [7:0] drive_ff, format_ff, pat_hi_ff, pat_lo_ff, iface_ff, fall_ff;
   reg [7:0] power_ff, hifreq_ff, ped_ff, loop_ff, slow_ff;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin // [RQ23]
         drive_ff  <= `ACR_RST_VAL;
         format_ff <= `ACR_RST_VAL;
         pat_hi_ff <= `ACR_RST_VAL;
         pat_lo_ff <= `ACR_RST_VAL;
         iface_ff  <= `ACR_RST_VAL;
         fall_ff   <= `ACR_RST_VAL;
         power_ff  <= `ACR_RST_VAL;
         hifreq_ff <= `ACR_RST_VAL;
         ped_ff    <= `ACR_RST_VAL;
         loop_ff   <= `ACR_RST_VAL;
         slow_ff   <= `ACR_RST_VAL;
      end else if (clr) begin // software reset restores defaults [RQ23]
         drive_ff  <= `ACR_RST_VAL;
         format_ff <= `ACR_RST_VAL;
         pat_hi_ff <= `ACR_RST_VAL;
         pat_lo_ff <= `ACR_RST_VAL;
         iface_ff  <= `ACR_RST_VAL;
         fall_ff   <= `ACR_RST_VAL;
         power_ff  <= `ACR_RST_VAL;
         hifreq_ff <= `ACR_RST_VAL;
         ped_ff    <= `ACR_RST_VAL;
         loop_ff   <= `ACR_RST_VAL;
         slow_ff   <= `ACR_RST_VAL;
      end else if (wr_go) begin // whole byte at once, held until rewritten [RQ24] [RQ25]
         // a write that meets the software reset is lost, the clear wins
         case (addr_ff)
            `ACR_A_DRIVE:    drive_ff  <= data_ff;
            `ACR_A_FORMAT:   format_ff <= data_ff;
            `ACR_A_PAT_HI:   pat_hi_ff <= data_ff;
            `ACR_A_PAT_LO:   pat_lo_ff <= data_ff;
            `ACR_A_IFACE:    iface_ff  <= data_ff;
            `ACR_A_FALL:     fall_ff   <= data_ff;
            `ACR_A_POWER:    power_ff  <= data_ff;
            `ACR_A_HIFREQ:   hifreq_ff <= data_ff;
            `ACR_A_PEDESTAL: ped_ff    <= data_ff;
            `ACR_A_LOOP:     loop_ff   <= data_ff;
            // slow variants must leave this field alone; drop the write there [RQ21]
            `ACR_A_SLOW:     if (FAST_VARIANT) slow_ff <= data_ff;
            default: ; // unmapped addresses are ignored
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field decode
   wire [1:0] fmt_code  = format_ff[`ACR_F_FMT_HI:`ACR_F_FMT_LO];
   wire [1:0] std_code  = iface_ff[`ACR_F_STD_HI:`ACR_F_STD_LO];
   wire [1:0] rise_code = iface_ff[`ACR_F_RISE_HI:`ACR_F_RISE_LO];
   wire [1:0] fall_code = fall_ff[`ACR_F_FALL_HI:`ACR_F_FALL_LO];
   wire       pin_lvl   = pin_sync_ff[1];
   // short path off clear keeps the low latency path with the offset loop and hold off
   wire       digi_on   = fall_ff[`ACR_B_SHORT_OFF];
   wire       fsleep    = power_ff[`ACR_B_FSLEEP];
   wire       qsleep    = fall_ff[`ACR_B_QSLEEP];

   reg        nxt_twos;
   reg        nxt_ddr;
   reg [10:0] nxt_rise_ps;
   reg        nxt_rise_al;
   reg [10:0] nxt_fall_ps;
   reg        nxt_fall_al;
   reg [13:0] nxt_word;

   // format and standard decode; code 01 of format treated as pin-driven
   always @* begin
      case (fmt_code)
         `ACR_FMT_TWOS:   nxt_twos = 1'b1;  // [RQ2]
         `ACR_FMT_OFFBIN: nxt_twos = 1'b0;  // [RQ2]
         default:         nxt_twos = pin_lvl; // [RQ2]
      endcase
      case (std_code)
         `ACR_STD_DDR: nxt_ddr = 1'b1;   // [RQ5]
         `ACR_STD_PAR: nxt_ddr = 1'b0;   // [RQ5]
         default:      nxt_ddr = pin_lvl; // [RQ5]
      endcase
      // pattern word is passed as written; choosing it as output is done elsewhere
      // narrow part drives only the upper twelve bits of the pattern
      nxt_word = {pat_hi_ff, pat_lo_ff[7:2]}; // [RQ4]
      if (!WIDE_VARIANT)
         nxt_word[1:0] = 2'h0; // [RQ4]
   end

   // edge shift decode in picoseconds, zero when adjustment disabled
   always @* begin
      nxt_rise_ps = 11'h000;
      nxt_rise_al = 1'b0;
      nxt_fall_ps = 11'h000;
      nxt_fall_al = 1'b0;
      // picoseconds fit eleven bits; the largest shift is 1500
      // rising edge position, gated by its own enable
      if (iface_ff[`ACR_B_RISE_EN]) begin // [RQ6]
         if (nxt_ddr) begin
            case (rise_code)
               2'h1:    nxt_rise_ps = 11'd500; // [RQ7]
               2'h2:    nxt_rise_al = 1'b1;    // [RQ7]
               2'h3:    nxt_rise_ps = 11'd200; // [RQ7]
               default: nxt_rise_ps = 11'h000;
            endcase
         end else begin
            case (rise_code)
               2'h1:    nxt_rise_ps = 11'd100;  // [RQ8]
               2'h2:    nxt_rise_ps = 11'd200;  // [RQ8]
               2'h3:    nxt_rise_ps = 11'd1500; // [RQ8]
               default: nxt_rise_ps = 11'h000;
            endcase
         end
      end
      // falling edge position, gated by the interface register bit 0
      if (iface_ff[`ACR_B_FALL_EN]) begin // [RQ9]
         if (nxt_ddr) begin
            case (fall_code)
               2'h1:    nxt_fall_ps = 11'd400; // [RQ10]
               2'h2:    nxt_fall_al = 1'b1;    // [RQ10]
               2'h3:    nxt_fall_ps = 11'd200; // [RQ10]
               default: nxt_fall_ps = 11'h000;
            endcase
         end else begin
            case (fall_code)
               2'h1:    nxt_fall_ps = 11'd100;  // [RQ11]
               2'h2:    nxt_fall_ps = 11'd200;  // [RQ11]
               2'h3:    nxt_fall_ps = 11'd1500; // [RQ11]
               default: nxt_fall_ps = 11'h000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs, one cycle after the storage changes
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         // reset state: everything powered, loop period at its shortest
         clock_drive_double   <= 1'b0;
         data_drive_double    <= 1'b0;
         twos_complement_out  <= 1'b0;
         offset_loop_enable   <= 1'b0;
         fixed_output_word    <= 14'h0000;
         ddr_output           <= 1'b0;
         cmos_clk_strength    <= 2'h0;
         rise_shift_ps        <= 11'h000;
         rise_align           <= 1'b0;
         fall_shift_ps        <= 11'h000;
         fall_align           <= 1'b0;
         short_path_off       <= 1'b0;
         core_powered         <= 1'b1;
         ref_powered          <= 1'b1;
         out_buf_powered      <= 1'b1;
         pins_hiz             <= 1'b0;
         swing_override       <= 1'b0;
         swing_value          <= 6'h00;
         high_freq_boost      <= 1'b0;
         offset_target        <= 6'h00;
         offset_estimate_hold <= 1'b0;
         offset_loop_log2     <= `ACR_PER_BASE_LOG;
         slow_rate_mode       <= 1'b0;
      end else begin
         clock_drive_double   <= drive_ff[`ACR_B_CLK_DBL];  // [RQ1]
         data_drive_double    <= drive_ff[`ACR_B_DATA_DBL]; // [RQ1]
         twos_complement_out  <= nxt_twos;
         fixed_output_word    <= nxt_word;
         ddr_output           <= nxt_ddr;
         cmos_clk_strength    <= iface_ff[`ACR_F_CSTR_HI:`ACR_F_CSTR_LO];
         rise_shift_ps        <= nxt_rise_ps;
         rise_align           <= nxt_rise_al;
         fall_shift_ps        <= nxt_fall_ps;
         fall_align           <= nxt_fall_al;
         // low latency path gates only the offset correction loop and its hold; the pattern word still passes
         short_path_off       <= digi_on; // [RQ12]
         offset_loop_enable   <= format_ff[`ACR_B_OFS_EN] & digi_on; // [RQ3] [RQ12]
         // reference survives quick sleep for a fast wake-up
         core_powered         <= ~(fsleep | qsleep); // [RQ13] [RQ14]
         ref_powered          <= ~fsleep; // [RQ14]
         out_buf_powered      <= ~(fsleep | qsleep | power_ff[`ACR_B_PINS_OFF]); // [RQ13]
         pins_hiz             <= power_ff[`ACR_B_PINS_OFF]; // [RQ15]
         // codes 01 and 10 are forbidden; treated as off
         // swing value forced to zero so a stale code never reaches the drivers
         swing_override       <= (power_ff[`ACR_F_SWOV_HI:`ACR_F_SWOV_LO]
                                  == `ACR_SWOV_ON); // [RQ16]
         swing_value          <= (power_ff[`ACR_F_SWOV_HI:`ACR_F_SWOV_LO] == `ACR_SWOV_ON)
                                 ? swing_code : 6'h00; // [RQ16]
         // boost is only passed on; the controller decides when to set it
         high_freq_boost      <= hifreq_ff[`ACR_B_HFBOOST];
         // pedestal passed as signed, the loop adds it to mid-code
         offset_target        <= ped_ff[`ACR_F_PED_HI:`ACR_F_PED_LO]; // [RQ18]
         offset_estimate_hold <= loop_ff[`ACR_B_HOLD] & format_ff[`ACR_B_OFS_EN]
                                 & digi_on; // [RQ19]
         // codes above 1011 are clamped to the longest period
         offset_loop_log2     <= (loop_ff[`ACR_F_PER_HI:`ACR_F_PER_LO] > `ACR_PER_MAX_CODE)
                                 ? (`ACR_PER_BASE_LOG + {1'b0, `ACR_PER_MAX_CODE})
                                 : (`ACR_PER_BASE_LOG
                                    + {1'b0, loop_ff[`ACR_F_PER_HI:`ACR_F_PER_LO]}); // [RQ20]
         // slow variants tie the mode off whatever the register holds
         slow_rate_mode       <= FAST_VARIANT // [RQ21]
                                 & (slow_ff[`ACR_F_SLOW_HI:`ACR_F_SLOW_LO] == `ACR_SLOW_ON);
      end
   end

endmodule // acr_cfg_regs

// >>> shared/acr_map.vh
// register offsets, field positions, reset values and timing counts of the output config bank
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// register addresses (8-bit serial address space)
`define ACR_A_DRIVE      8'h26
`define ACR_A_FORMAT     8'h3d
`define ACR_A_PAT_HI     8'h3f
`define ACR_A_PAT_LO     8'h40
`define ACR_A_IFACE      8'h41
`define ACR_A_FALL       8'h42
`define ACR_A_POWER      8'h43
`define ACR_A_HIFREQ     8'h4a
`define ACR_A_PEDESTAL   8'hbf
`define ACR_A_LOOP       8'hcf
`define ACR_A_SLOW       8'hdf
// reset value of every register
`define ACR_RST_VAL      8'h00
// field positions
`define ACR_B_DATA_DBL   0
`define ACR_B_CLK_DBL    1
`define ACR_F_FMT_HI     7
`define ACR_F_FMT_LO     6
`define ACR_B_OFS_EN     5
`define ACR_F_STD_HI     7
`define ACR_F_STD_LO     6
`define ACR_F_CSTR_HI    5
`define ACR_F_CSTR_LO    4
`define ACR_B_RISE_EN    3
`define ACR_F_RISE_HI    2
`define ACR_F_RISE_LO    1
`define ACR_B_FALL_EN    0
`define ACR_F_FALL_HI    7
`define ACR_F_FALL_LO    6
`define ACR_B_SHORT_OFF  3
`define ACR_B_QSLEEP     2
`define ACR_B_FSLEEP     6
`define ACR_B_PINS_OFF   4
`define ACR_F_SWOV_HI    1
`define ACR_F_SWOV_LO    0
`define ACR_B_HFBOOST    0
`define ACR_F_PED_HI     7
`define ACR_F_PED_LO     2
`define ACR_B_HOLD       7
`define ACR_F_PER_HI     5
`define ACR_F_PER_LO     2
`define ACR_F_SLOW_HI    5
`define ACR_F_SLOW_LO    4
// field codes
`define ACR_FMT_PIN      2'h0
`define ACR_FMT_TWOS     2'h2
`define ACR_FMT_OFFBIN   2'h3
`define ACR_STD_DDR      2'h1
`define ACR_STD_PAR      2'h3
`define ACR_SWOV_ON      2'h3
`define ACR_SLOW_ON      2'h3
// loop period: code 0 gives 2^20 sample clocks, each step doubles
`define ACR_PER_BASE_LOG 5'h14
`define ACR_PER_MAX_CODE 4'hb
`endif

// >>> tb/acr_cfg_sva.sv
// concurrent checks on the output configuration register bank
`timescale 1ns/100ps
`include "acr_map.vh"
module acr_cfg_sva #(
   parameter FAST_VARIANT = 1'b1
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        wr_stb,
   input wire logic [7:0]  wr_addr,
   input wire logic [7:0]  wr_data,
   input wire logic        sw_reset,
   input wire logic        twos_complement_out,
   input wire logic        offset_loop_enable,
   input wire logic        ddr_output,
   input wire logic [10:0] rise_shift_ps,
   input wire logic        rise_align,
   input wire logic        core_powered,
   input wire logic        ref_powered,
   input wire logic        out_buf_powered,
   input wire logic        pins_hiz,
   input wire logic        offset_estimate_hold,
   input wire logic [4:0]  offset_loop_log2,
   input wire logic        slow_rate_mode
);
   logic [2:0] idle_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // quiet cycles since the last strobe or software reset; 7 leaves room for the write pipeline
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         idle_ff <= 3'h0;
      else if (wr_stb || sw_reset)
         idle_ff <= 3'h0;
      else if (idle_ff != 3'h7)
         idle_ff <= idle_ff + 3'h1;
   end
   // outputs answer three edges after the strobe is seen rising; the checks below look five edges on
   stable_cfg_a: assert property (idle_ff == 3'h7 |->
      $stable({pins_hiz, slow_rate_mode, rise_shift_ps, offset_loop_log2}))
      else $error("config output moved without a write");
   sleep_order_a: assert property (!ref_powered |-> !core_powered && !out_buf_powered)
      else $error("reference off while core or buffers powered");
   pins_buf_a: assert property (pins_hiz |-> !out_buf_powered)
      else $error("pins floating with buffers powered");
   hold_needs_en_a: assert property (offset_estimate_hold |-> offset_loop_enable)
      else $error("estimate held with loop off");
   power_wr_a: assert property ($rose(wr_stb) && wr_addr == `ACR_A_POWER |-> ##5
      pins_hiz == $past(wr_data[4], 5) && ref_powered != $past(wr_data[6], 5))
      else $error("power write not applied as one");
   fmt_force_a: assert property ($rose(wr_stb) && wr_addr == `ACR_A_FORMAT
      && wr_data[7] |-> ##5 twos_complement_out != $past(wr_data[6], 5))
      else $error("forced number format wrong");
   std_force_a: assert property ($rose(wr_stb) && wr_addr == `ACR_A_IFACE
      && wr_data[6] |-> ##5 ddr_output != $past(wr_data[7], 5))
      else $error("forced output standard wrong");
   rise_gate_a: assert property ($rose(wr_stb) && wr_addr == `ACR_A_IFACE
      && !wr_data[3] |-> ##5 rise_shift_ps == 11'h000 && !rise_align)
      else $error("rise shift active while disabled");
   loop_code_a: assert property ($rose(wr_stb) && wr_addr == `ACR_A_LOOP
      && wr_data[5:2] <= 4'hb |-> ##5 offset_loop_log2 == 5'h14 + $past(wr_data[5:2], 5))
      else $error("loop period code decoded wrong");
   slow_code_a: assert property ($rose(wr_stb) && wr_addr == `ACR_A_SLOW
      |-> ##5 slow_rate_mode == (FAST_VARIANT && $past(wr_data[5:4], 5) == 2'h3))
      else $error("slow rate mode decoded wrong");
   cover property ($rose(pins_hiz));
   cover property (!ref_powered);
   cover property (offset_estimate_hold);
endmodule // acr_cfg_sva

bind acr_cfg_regs acr_cfg_sva #(.FAST_VARIANT(FAST_VARIANT)) u_sva (.*);

// >>> tb/acr_ctl_model.sv
// stand-in for the serial front end: register writes and software reset
`timescale 1ns/100ps
`include "acr_map.vh"
module acr_ctl_model (
   input  wire logic       sys_clk,
   output logic            wr_stb,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            sw_reset
);
   initial begin
      wr_stb = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      sw_reset = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // callers pass unused bits as zero; swing enable codes 01/10 never leave
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      wr_addr = a;
      wr_data = d;
      if (a == `ACR_A_POWER && ^d[1:0])
         wr_data[1:0] = 2'h0;
      wr_stb = 1'b1;
      repeat (3) @(negedge sys_clk);
      wr_stb = 1'b0;
      // released lines must not keep looking like the last byte
      wr_addr = ~a;
      wr_data = ~d;
      // long enough quiet gap for the checker to see settled outputs
      repeat (7) @(negedge sys_clk);
   endtask
   // software reset bit clears itself after a short pulse
   task automatic sw_pulse;
      @(negedge sys_clk);
      sw_reset = 1'b1;
      repeat (4) @(negedge sys_clk);
      sw_reset = 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask
endmodule // acr_ctl_model

// >>> tb/tb_top.sv
// self-checking bench for the output configuration register bank
`timescale 1ns/100ps
`include "acr_map.vh"
module tb_top;
   logic        sys_clk, rst, format_select_pin, wr_stb, sw_reset;
   logic [7:0]  wr_addr, wr_data;
   logic [5:0]  swing_code, swing_value, offset_target;
   logic        clock_drive_double, data_drive_double, twos_complement_out;
   logic        offset_loop_enable, ddr_output, rise_align, fall_align;
   logic        short_path_off, core_powered, ref_powered, out_buf_powered;
   logic        pins_hiz, swing_override, high_freq_boost;
   logic        offset_estimate_hold, slow_rate_mode;
   logic [13:0] fixed_output_word;
   logic [1:0]  cmos_clk_strength;
   logic [10:0] rise_shift_ps, fall_shift_ps;
   logic [4:0]  offset_loop_log2;
   int          fails = 0;
   int          check_count = 0;

   acr_cfg_regs uut (.*);
   acr_ctl_model ctl (.*);
   ////////////////////////////////////////////////////////////////////////////
   // clock and verdict plumbing
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_defaults;
      @(negedge sys_clk);
      chk("powered", {core_powered, ref_powered, out_buf_powered}, 3'h7);
      chk("log2", offset_loop_log2, 5'h14);
      chk("cfg", {pins_hiz, slow_rate_mode, high_freq_boost, fixed_output_word}, 0);
   endtask
   // every format and standard code, pin low and high
   task automatic t_format;
      logic [1:0] cd[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
      for (int k = 0; k < 8; k++) begin
         format_select_pin = k[0];
         ctl.write(`ACR_A_FORMAT, {cd[k[2:1]], 6'h00});
         ctl.write(`ACR_A_IFACE, {k[2:1], 6'h00});
         chk("twos", twos_complement_out,
             cd[k[2:1]][1] ? cd[k[2:1]] == 2'h2 : k[0]);
         chk("ddr", ddr_output, k[1] ? k[2:1] == 2'h1 : k[0]);
      end
      ctl.write(`ACR_A_FORMAT, 8'h20);
      chk("ofs_short", offset_loop_enable, 1'b0);
      ctl.write(`ACR_A_FALL, 8'h08);
      chk("ofs_en", {offset_loop_enable, short_path_off}, 2'h3);
   endtask
   task automatic t_pattern;
      ctl.write(`ACR_A_PAT_HI, 8'hb5);
      ctl.write(`ACR_A_PAT_LO, 8'h9c);
      chk("pattern", fixed_output_word, {8'hb5, 6'h27});
      ctl.write(`ACR_A_DRIVE, 8'h02);
      chk("drive", {clock_drive_double, data_drive_double}, 2'h2);
      ctl.write(`ACR_A_DRIVE, 8'h01);
      chk("drive", {clock_drive_double, data_drive_double}, 2'h1);
   endtask
   // differential then single-ended, all four edge codes each
   task automatic t_edges;
      logic [10:0] rd[8] = '{0, 500, 0, 200, 0, 100, 200, 1500};
      logic [10:0] fd[8] = '{0, 400, 0, 200, 0, 100, 200, 1500};
      for (int k = 0; k < 8; k++) begin
         ctl.write(`ACR_A_IFACE, {k[2] ? 2'h3 : 2'h1, k[1:0], 1'b1, k[1:0], 1'b1});
         ctl.write(`ACR_A_FALL, {k[1:0], 6'h08});
         chk("rise", {rise_align, rise_shift_ps}, {k[2:0] == 3'h2, rd[k]});
         chk("fall", {fall_align, fall_shift_ps}, {k[2:0] == 3'h2, fd[k]});
         chk("cstr", cmos_clk_strength, k[1:0]);
      end
      ctl.write(`ACR_A_IFACE, 8'h46);
      chk("gated", {rise_shift_ps, fall_shift_ps}, 0);
   endtask
   task automatic t_power;
      ctl.write(`ACR_A_FALL, 8'h0c);
      chk("qsleep", {core_powered, ref_powered, out_buf_powered}, 3'h2);
      ctl.write(`ACR_A_FALL, 8'h08);
      ctl.write(`ACR_A_POWER, 8'h40);
      chk("fsleep", {core_powered, ref_powered, out_buf_powered, pins_hiz}, 4'h0);
      ctl.write(`ACR_A_POWER, 8'h13);
      chk("pins", {core_powered, ref_powered, out_buf_powered, pins_hiz, swing_override},
          5'h1b);
      chk("swing", swing_value, swing_code);
      ctl.write(`ACR_A_POWER, 8'h00);
      chk("swing_off", {swing_override, pins_hiz, swing_value}, 8'h00);
   endtask
   task automatic t_loop;
      ctl.write(`ACR_A_HIFREQ, 8'h01);
      chk("boost", high_freq_boost, 1'b1);
      ctl.write(`ACR_A_PEDESTAL, 8'h80);
      chk("target", offset_target, 6'h20);
      ctl.write(`ACR_A_LOOP, 8'h9c);
      chk("loop", {offset_estimate_hold, offset_loop_log2}, {1'b1, 5'h1b});
      ctl.write(`ACR_A_FORMAT, 8'h00);
      chk("hold_off", offset_estimate_hold, 1'b0);
      // codes above the longest period clamp to it
      ctl.write(`ACR_A_LOOP, 8'h3c);
      chk("clamp", offset_loop_log2, 5'h1f);
      ctl.write(`ACR_A_SLOW, 8'h30);
      chk("slow", slow_rate_mode, 1'b1);
      ctl.write(`ACR_A_SLOW, 8'h20);
      chk("slow", slow_rate_mode, 1'b0);
      ctl.write(8'h55, 8'hff);
      chk("unmapped", {high_freq_boost, offset_target, offset_loop_log2},
          {1'b1, 6'h20, 5'h1f});
      ctl.sw_pulse;
      t_defaults;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence; watchdog cuts a hang short
   initial begin
      rst = 1'b1;
      format_select_pin = 1'b0;
      swing_code = 6'h2b;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      t_defaults;
      t_format;
      t_pattern;
      t_edges;
      t_power;
      t_loop;
      results;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      results;
   end
endmodule // tb_top
